// File: lsl_pkg.sv
// Package of constants for the layer-2 service lookup and interrupt block
package lsl_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_FWD_CFG = 8'h00;
    localparam logic [7:0] REG_PORT_CFG = 8'h04;
    localparam logic [7:0] REG_SVC_SEL = 8'h08;
    localparam logic [7:0] REG_SVC_CTRL = 8'h0c;
    localparam logic [7:0] REG_SVC_MASK = 8'h10;
    localparam logic [7:0] REG_SVC_MISC = 8'h14;
    localparam logic [7:0] REG_SVC_DLB = 8'h18;
    localparam logic [7:0] REG_SVC_STAT = 8'h1c;
    localparam logic [7:0] REG_COS_OFS = 8'h20;
    localparam logic [7:0] REG_IRQ_STAT = 8'h24;
    localparam logic [7:0] REG_IRQ_MASK = 8'h28;
    localparam logic [7:0] REG_IRQ_CAUSE = 8'h2c;
    localparam logic [7:0] REG_LIMIT_CFG = 8'h30;
    // Global config fields
    localparam int FWD_LOOKUP_BIT = 0;
    localparam int FWD_PORT_BUNDLE_BIT = 1;
    localparam int FWD_QUEUE_SVC_BIT = 2;
    // Service control fields
    localparam int SC_MASK_SUB = 0;
    localparam int SC_SRC_OFF = 1;
    localparam int SC_LAG_OVR = 2;
    localparam int SC_LAG_VAL_LSB = 3;
    localparam int SC_FWD_EN = 7;
    localparam int SC_DEST_EN = 8;
    localparam int SC_LEARN_EN = 9;
    localparam int SC_KIND_LSB = 10;
    localparam int SC_TGT_LSB = 16;
    // Misc fields
    localparam int MI_FLOOD_OVR = 31;
    localparam int MI_STAGE_LSB = 24;
    // Forward kinds
    localparam logic [2:0] KIND_GROUP = 3'h3;
    localparam logic [2:0] KIND_FLOOD = 3'h7;
    // Forward decisions
    localparam logic [1:0] DEC_DEST = 2'h0;
    localparam logic [1:0] DEC_FLOOD = 2'h1;
    localparam logic [1:0] DEC_GROUP = 2'h2;
    // Interrupt source bits
    localparam int IRQ_RULE = 0;
    localparam int IRQ_PORT_CAP = 1;
    localparam int IRQ_GROUP_CAP = 2;
    localparam int IRQ_ACCESS = 3;
    localparam int IRQ_N = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: lsl_service_lookup.sv
// Layer-2 service lookup, policer and statistics indexing, analyzer interrupts
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Service table only affects frames when global lookup enable is set.
// - Unassigned frame with port bundle default enabled uses port bundle pointer.
// - Unassigned frame with queue default uses queue base plus internal priority.
// - Service mask reduces VLAN mask, or replaces it when substitute flag set.
// - Source filtering skipped when service source filter off flag is set.
// - Service may disable lag contribution or force the configured lag value.
// - Service forward on and dest lookup off: decision comes from service.
// - Kind 7 gives flood; kind 3 gives group decision at target index.
// - Service learning uses service kind and target as learn interface.
// - Service policer index is service base plus class offset.
// - Service-hit frames dropped before the service policing stage are not policed; their statistics index is still given.
// - Bundle policer comes from the service entry bundle pointer.
// - Flood policer from VLAN unless service override enabled.
// - Statistics index is service base plus class offset.
// - Sticky status and enable per source, readable active causes.
// - Rule hit with interrupt action raises rule source.
// - Port learn cap exceed raises source when port enable set.
// - Group learn cap exceed raises source when group enable set.
// - Table access completion raises its source.
module lsl_service_lookup #(
    parameter int PORTS = 8,
    parameter int COS_N = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Frame from classifier
    input wire logic frm_valid_i,
    input wire logic [7:0] frm_service_index_i,
    input wire logic [2:0] frm_internal_priority_i,
    input wire logic [2:0] frm_class_of_service_id_i,
    input wire logic [PORTS-1:0] frm_vlan_mask_i,
    input wire logic [7:0] frm_vlan_flood_ptr_i,
    input wire logic [PORTS-1:0] frm_src_port_mask_i,
    input wire logic [3:0] frm_lag_code_i,
    input wire logic [7:0] frm_port_i,
    input wire logic [2:0] frm_drop_stage_i,
    // Events from other stages
    input wire logic rule_hit_irq_i,
    input wire logic port_learn_cap_irq_i,
    input wire logic group_learn_cap_irq_i,
    input wire logic table_access_done_irq_i,
    // Frame result
    output logic res_valid_o,
    output logic [PORTS-1:0] res_port_mask_o,
    output logic res_src_filter_en_o,
    output logic res_lag_en_o,
    output logic [3:0] res_lag_code_o,
    output logic [1:0] res_decision_o,
    output logic [7:0] res_group_idx_o,
    output logic res_learn_svc_o,
    output logic [10:0] res_learn_if_o,
    output logic res_police_en_o,
    output logic [7:0] res_service_policer_o,
    output logic [7:0] res_bundle_policer_o,
    output logic [7:0] res_flood_policer_o,
    output logic [7:0] res_stat_idx_o,
    // Interrupt
    output logic irq_o
);
    // Single-entry service table view: the selected entry is the one named by
    // the service select register; a full table lives beyond this stage.
    logic [31:0] fwd_cfg_r, port_cfg_r, svc_sel_r, svc_ctrl_r, svc_mask_r;
    logic [31:0] svc_misc_r, svc_dlb_r, svc_stat_r, cos_ofs_r, limit_cfg_r;
    logic [lsl_pkg::IRQ_N-1:0] irq_stat_r, irq_mask_r, irq_stat_nxt;
    logic aw_got_r, w_got_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;

    // Frame decode
    wire logic lookup_en = fwd_cfg_r[lsl_pkg::FWD_LOOKUP_BIT];
    wire logic no_svc = (frm_service_index_i == 8'h00);
    wire logic hit = lookup_en && !no_svc && (frm_service_index_i == svc_sel_r[7:0]);
    wire logic [2:0] fwd_kind = svc_ctrl_r[lsl_pkg::SC_KIND_LSB +: 3];
    wire logic [10:0] fwd_tgt = svc_ctrl_r[lsl_pkg::SC_TGT_LSB +: 11];
    wire logic svc_fwd = hit && svc_ctrl_r[lsl_pkg::SC_FWD_EN]
        && !svc_ctrl_r[lsl_pkg::SC_DEST_EN];
    wire logic [PORTS-1:0] svc_mask = svc_mask_r[PORTS-1:0];
    wire logic [PORTS-1:0] mask_sel = !hit ? frm_vlan_mask_i :
        svc_ctrl_r[lsl_pkg::SC_MASK_SUB] ? svc_mask : (frm_vlan_mask_i & svc_mask);
    wire logic [1:0] dec = !svc_fwd ? lsl_pkg::DEC_DEST :
        (fwd_kind == lsl_pkg::KIND_FLOOD) ? lsl_pkg::DEC_FLOOD :
        (fwd_kind == lsl_pkg::KIND_GROUP) ? lsl_pkg::DEC_GROUP : lsl_pkg::DEC_DEST;
    wire logic [7:0] cos_ofs = {4'h0, cos_ofs_r[{frm_class_of_service_id_i, 2'b00} +: 4]};
    wire logic [7:0] svc_pol = svc_dlb_r[7:0] + cos_ofs;
    wire logic [7:0] q_pol = port_cfg_r[15:8] + {5'h00, frm_internal_priority_i};
    wire logic [7:0] stat_idx = svc_stat_r[7:0] + cos_ofs;
    wire logic [2:0] stage = svc_misc_r[lsl_pkg::MI_STAGE_LSB +: 3];
    // Drop stage 0 means the frame survived the whole pipeline
    wire logic early_drop = (frm_drop_stage_i != 3'h0) && (frm_drop_stage_i < stage);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            res_valid_o <= 1'b0;
            res_port_mask_o <= '0;
            res_src_filter_en_o <= 1'b1;
            res_lag_en_o <= 1'b1;
            res_lag_code_o <= 4'h0;
            res_decision_o <= lsl_pkg::DEC_DEST;
            res_group_idx_o <= 8'h00;
            res_learn_svc_o <= 1'b0;
            res_learn_if_o <= 11'h000;
            res_police_en_o <= 1'b0;
            res_service_policer_o <= 8'h00;
            res_bundle_policer_o <= 8'h00;
            res_flood_policer_o <= 8'h00;
            res_stat_idx_o <= 8'h00;
        end else begin
            res_valid_o <= frm_valid_i;
            res_port_mask_o <= mask_sel;
            res_src_filter_en_o <= !(hit && svc_ctrl_r[lsl_pkg::SC_SRC_OFF]);
            // Override off keeps the classifier code; forced value uses config
            res_lag_en_o <= !(hit && svc_ctrl_r[lsl_pkg::SC_LAG_OVR]
                && svc_ctrl_r[lsl_pkg::SC_LAG_VAL_LSB +: 4] == 4'h0);
            res_lag_code_o <= (hit && svc_ctrl_r[lsl_pkg::SC_LAG_OVR]) ?
                svc_ctrl_r[lsl_pkg::SC_LAG_VAL_LSB +: 4] : frm_lag_code_i;
            res_decision_o <= dec;
            res_group_idx_o <= fwd_tgt[7:0];
            res_learn_svc_o <= hit && svc_ctrl_r[lsl_pkg::SC_LEARN_EN];
            res_learn_if_o <= (hit && svc_ctrl_r[lsl_pkg::SC_LEARN_EN]) ?
                {fwd_kind == lsl_pkg::KIND_GROUP, fwd_tgt[9:0]} : {3'h0, frm_port_i};
            res_police_en_o <= frm_valid_i && !(hit && early_drop);
            res_service_policer_o <= hit ? svc_pol :
                (no_svc && fwd_cfg_r[lsl_pkg::FWD_QUEUE_SVC_BIT]) ? q_pol : 8'h00;
            res_bundle_policer_o <= hit ? svc_misc_r[7:0] :
                (no_svc && fwd_cfg_r[lsl_pkg::FWD_PORT_BUNDLE_BIT]) ? port_cfg_r[7:0] : 8'h00;
            res_flood_policer_o <= (hit && svc_misc_r[lsl_pkg::MI_FLOOD_OVR]) ?
                svc_misc_r[15:8] : frm_vlan_flood_ptr_i;
            res_stat_idx_o <= hit ? stat_idx : 8'h00;
        end
    end

    // Interrupt sources; event set beats write-one clear
    wire logic [lsl_pkg::IRQ_N-1:0] irq_evt = {table_access_done_irq_i,
        group_learn_cap_irq_i && limit_cfg_r[1],
        port_learn_cap_irq_i && limit_cfg_r[0],
        rule_hit_irq_i};
    wire logic wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    wire logic [lsl_pkg::IRQ_N-1:0] irq_clr = (wr_fire && aw_addr_r == lsl_pkg::REG_IRQ_STAT) ?
        w_data_r[lsl_pkg::IRQ_N-1:0] : '0;
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;
    wire logic [lsl_pkg::IRQ_N-1:0] irq_cause = irq_stat_r & irq_mask_r;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= lsl_pkg::REG_LIMIT_CFG);
    endfunction

    // Write channel: address and data accepted in either order
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= lsl_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_addr_r) ? lsl_pkg::RESP_OKAY : lsl_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
            end
        end
    end

    // Register stores; strobes are taken as whole-word for simplicity
    wire logic wr_en = wr_fire && (s_axi_wstrb != 4'h0 || 1'b1);
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            fwd_cfg_r <= 32'h0;
            port_cfg_r <= 32'h0;
            svc_sel_r <= 32'h0;
            svc_ctrl_r <= 32'h0;
            svc_mask_r <= 32'h0;
            svc_misc_r <= 32'h0;
            svc_dlb_r <= 32'h0;
            svc_stat_r <= 32'h0;
            cos_ofs_r <= 32'h0;
            limit_cfg_r <= 32'h0;
            irq_mask_r <= '0;
            irq_stat_r <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_o <= |(irq_stat_nxt & irq_mask_r);
            if (wr_en) begin
                case (aw_addr_r)
                    lsl_pkg::REG_FWD_CFG: fwd_cfg_r <= w_data_r;
                    lsl_pkg::REG_PORT_CFG: port_cfg_r <= w_data_r;
                    lsl_pkg::REG_SVC_SEL: svc_sel_r <= w_data_r;
                    lsl_pkg::REG_SVC_CTRL: svc_ctrl_r <= w_data_r;
                    lsl_pkg::REG_SVC_MASK: svc_mask_r <= w_data_r;
                    lsl_pkg::REG_SVC_MISC: svc_misc_r <= w_data_r;
                    lsl_pkg::REG_SVC_DLB: svc_dlb_r <= w_data_r;
                    lsl_pkg::REG_SVC_STAT: svc_stat_r <= w_data_r;
                    lsl_pkg::REG_COS_OFS: cos_ofs_r <= w_data_r;
                    lsl_pkg::REG_IRQ_MASK: irq_mask_r <= w_data_r[lsl_pkg::IRQ_N-1:0];
                    lsl_pkg::REG_LIMIT_CFG: limit_cfg_r <= w_data_r;
                    default: ;
                endcase
            end
        end
    end

    // Read channel
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        case (s_axi_araddr)
            lsl_pkg::REG_FWD_CFG: rd_val = fwd_cfg_r;
            lsl_pkg::REG_PORT_CFG: rd_val = port_cfg_r;
            lsl_pkg::REG_SVC_SEL: rd_val = svc_sel_r;
            lsl_pkg::REG_SVC_CTRL: rd_val = svc_ctrl_r;
            lsl_pkg::REG_SVC_MASK: rd_val = svc_mask_r;
            lsl_pkg::REG_SVC_MISC: rd_val = svc_misc_r;
            lsl_pkg::REG_SVC_DLB: rd_val = svc_dlb_r;
            lsl_pkg::REG_SVC_STAT: rd_val = svc_stat_r;
            lsl_pkg::REG_COS_OFS: rd_val = cos_ofs_r;
            lsl_pkg::REG_IRQ_STAT: rd_val = {28'h0, irq_stat_r};
            lsl_pkg::REG_IRQ_MASK: rd_val = {28'h0, irq_mask_r};
            lsl_pkg::REG_IRQ_CAUSE: rd_val = {28'h0, irq_cause};
            lsl_pkg::REG_LIMIT_CFG: rd_val = limit_cfg_r;
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= lsl_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= addr_ok(s_axi_araddr) ? lsl_pkg::RESP_OKAY : lsl_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    property p_sticky_set;
        @(posedge clk_i) disable iff (!reset_n_i)
        rule_hit_irq_i |=> irq_stat_r[lsl_pkg::IRQ_RULE];
    endproperty
    a_sticky_set: assert property (p_sticky_set) else $error("rule event lost");
    property p_port_cap;
        @(posedge clk_i) disable iff (!reset_n_i)
        (port_learn_cap_irq_i && limit_cfg_r[0]) |=> irq_stat_r[lsl_pkg::IRQ_PORT_CAP];
    endproperty
    a_port_cap: assert property (p_port_cap) else $error("port cap event lost");
    property p_group_cap;
        @(posedge clk_i) disable iff (!reset_n_i)
        (group_learn_cap_irq_i && limit_cfg_r[1]) |=> irq_stat_r[lsl_pkg::IRQ_GROUP_CAP];
    endproperty
    a_group_cap: assert property (p_group_cap) else $error("group cap event lost");
    property p_access;
        @(posedge clk_i) disable iff (!reset_n_i)
        table_access_done_irq_i |=> irq_stat_r[lsl_pkg::IRQ_ACCESS];
    endproperty
    a_access: assert property (p_access) else $error("access event lost");
    property p_irq_out;
        @(posedge clk_i) disable iff (!reset_n_i)
        irq_o == |(irq_stat_r & $past(irq_mask_r));
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq output mismatch");
    property p_no_lookup;
        @(posedge clk_i) disable iff (!reset_n_i)
        (frm_valid_i && !lookup_en) |=> res_port_mask_o == $past(frm_vlan_mask_i);
    endproperty
    a_no_lookup: assert property (p_no_lookup) else $error("mask changed without lookup");
    property p_flood;
        @(posedge clk_i) disable iff (!reset_n_i)
        (svc_fwd && fwd_kind == lsl_pkg::KIND_FLOOD) |=> res_decision_o == lsl_pkg::DEC_FLOOD;
    endproperty
    a_flood: assert property (p_flood) else $error("flood decision missing");
    property p_flood_pol;
        @(posedge clk_i) disable iff (!reset_n_i)
        !hit |=> res_flood_policer_o == $past(frm_vlan_flood_ptr_i);
    endproperty
    a_flood_pol: assert property (p_flood_pol) else $error("flood policer not from vlan");
endmodule // lsl_service_lookup
`default_nettype wire

// File: lsl_classifier_model.sv
// Behavioural model of the frame classifier feeding the service lookup block
`timescale 1ns/100ps
`default_nettype none
module lsl_classifier_model #(
    parameter int PORTS = 8
) (
    // Clock
    input wire logic clk_i,
    // Frame towards the analyzer
    output logic frm_valid_o,
    output logic [7:0] frm_service_index_o,
    output logic [2:0] frm_internal_priority_o,
    output logic [2:0] frm_class_of_service_id_o,
    output logic [PORTS-1:0] frm_vlan_mask_o,
    output logic [7:0] frm_vlan_flood_ptr_o,
    output logic [PORTS-1:0] frm_src_port_mask_o,
    output logic [3:0] frm_lag_code_o,
    output logic [7:0] frm_port_o,
    output logic [2:0] frm_drop_stage_o,
    // Event pulses, rule hit first
    output logic [3:0] ev_o
);
    initial begin
        frm_valid_o = 1'b0;
        {frm_service_index_o, frm_internal_priority_o, frm_class_of_service_id_o} = '1;
        {frm_vlan_mask_o, frm_vlan_flood_ptr_o, frm_src_port_mask_o} = '1;
        {frm_lag_code_o, frm_port_o, frm_drop_stage_o} = '1;
        ev_o = 4'h0;
    end
    // Fixed VLAN side fields keep the call short; the bench knows them
    task automatic send_frame(input logic [7:0] idx, input logic [2:0] prio,
                              input logic [2:0] cos, input logic [2:0] drop);
        @(posedge clk_i);
        frm_valid_o <= 1'b1;
        frm_service_index_o <= idx;
        frm_internal_priority_o <= prio;
        frm_class_of_service_id_o <= cos;
        frm_vlan_mask_o <= PORTS'(8'h3c);
        frm_vlan_flood_ptr_o <= 8'h77;
        frm_src_port_mask_o <= PORTS'(8'h01);
        frm_lag_code_o <= 4'h6;
        frm_port_o <= 8'h02;
        frm_drop_stage_o <= drop;
        @(posedge clk_i);
        // Idle fields flip so stale values never look valid
        frm_valid_o <= 1'b0;
        frm_service_index_o <= ~frm_service_index_o;
        frm_internal_priority_o <= ~frm_internal_priority_o;
        frm_class_of_service_id_o <= ~frm_class_of_service_id_o;
        frm_vlan_mask_o <= ~frm_vlan_mask_o;
        frm_vlan_flood_ptr_o <= ~frm_vlan_flood_ptr_o;
        frm_src_port_mask_o <= ~frm_src_port_mask_o;
        frm_lag_code_o <= ~frm_lag_code_o;
        frm_port_o <= ~frm_port_o;
        frm_drop_stage_o <= ~frm_drop_stage_o;
        #1;
    endtask
    task automatic pulse(input logic [3:0] ev);
        @(posedge clk_i);
        ev_o <= ev;
        @(posedge clk_i);
        ev_o <= 4'h0;
    endtask
endmodule // lsl_classifier_model
`default_nettype wire

// File: lsl_service_lookup_tb.sv
// Self-checking bench for the service lookup and interrupt block
`timescale 1ns/100ps
`default_nettype none
module lsl_service_lookup_tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq_o, v_o, sf_o, lag_en_o, lrn_o, pol_o;
    logic [1:0] bresp, rresp, resp, dec_o;
    logic [7:0] mask_o, grp_o, spol_o, bpol_o, fpol_o, stat_o, fv_idx, fv_ptr, fv_port;
    logic [2:0] fv_prio, fv_cos, fv_drop;
    logic [7:0] fv_vlan, fv_src;
    logic [3:0] fv_lag, lag_o, ev;
    logic [10:0] lif_o;
    logic fv_valid;
    int n_errors = 0;
    int total_checks = 0;
    always #5 clk_i = ~clk_i;
    lsl_classifier_model lsl_classifier_model_inst (.clk_i(clk_i),
        .frm_valid_o(fv_valid), .frm_service_index_o(fv_idx), .frm_internal_priority_o(fv_prio),
        .frm_class_of_service_id_o(fv_cos), .frm_vlan_mask_o(fv_vlan),
        .frm_vlan_flood_ptr_o(fv_ptr), .frm_src_port_mask_o(fv_src), .frm_lag_code_o(fv_lag),
        .frm_port_o(fv_port), .frm_drop_stage_o(fv_drop), .ev_o(ev));
    lsl_service_lookup lsl_service_lookup_inst (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .frm_valid_i(fv_valid), .frm_service_index_i(fv_idx), .frm_internal_priority_i(fv_prio),
        .frm_class_of_service_id_i(fv_cos), .frm_vlan_mask_i(fv_vlan),
        .frm_vlan_flood_ptr_i(fv_ptr), .frm_src_port_mask_i(fv_src), .frm_lag_code_i(fv_lag),
        .frm_port_i(fv_port), .frm_drop_stage_i(fv_drop), .rule_hit_irq_i(ev[0]),
        .port_learn_cap_irq_i(ev[1]), .group_learn_cap_irq_i(ev[2]),
        .table_access_done_irq_i(ev[3]), .res_valid_o(v_o), .res_port_mask_o(mask_o),
        .res_src_filter_en_o(sf_o), .res_lag_en_o(lag_en_o), .res_lag_code_o(lag_o),
        .res_decision_o(dec_o), .res_group_idx_o(grp_o), .res_learn_svc_o(lrn_o),
        .res_learn_if_o(lif_o), .res_police_en_o(pol_o), .res_service_policer_o(spol_o),
        .res_bundle_policer_o(bpol_o), .res_flood_policer_o(fpol_o), .res_stat_idx_o(stat_o),
        .irq_o(irq_o));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        wstrb <= 4'hf;
        forever begin
            @(posedge clk_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata; r = rresp; rready <= 1'b0;
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd, resp);
        check(rd, exp);
        check(resp, lsl_pkg::RESP_OKAY);
    endtask
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        check(sf_o, 1'b1); check(lag_en_o, 1'b1);
        rd_check(lsl_pkg::REG_IRQ_STAT, 32'h0);
        axi_read(8'h40, rd, resp);
        check(resp, lsl_pkg::RESP_SLVERR); check(rd, 32'h0);
        axi_write(8'h40, 32'h0);
        check(bresp, lsl_pkg::RESP_SLVERR);
        $display("reset and unmapped access done");
        // Entry 5 held; flood forward, reduced mask, lag off
        axi_write(lsl_pkg::REG_SVC_SEL, 32'h5);
        check(bresp, lsl_pkg::RESP_OKAY);
        axi_write(lsl_pkg::REG_SVC_CTRL, 32'h1c86);
        axi_write(lsl_pkg::REG_SVC_MASK, 32'h0f);
        axi_write(lsl_pkg::REG_SVC_MISC, 32'h8300_6633);
        axi_write(lsl_pkg::REG_SVC_DLB, 32'h10);
        axi_write(lsl_pkg::REG_SVC_STAT, 32'h80);
        axi_write(lsl_pkg::REG_COS_OFS, 32'h9876_5432);
        lsl_classifier_model_inst.send_frame(8'h5, 3'h0, 3'h0, 3'h0);
        check(v_o, 1'b1); check(mask_o, 8'h3c);
        check(dec_o, lsl_pkg::DEC_DEST); check(sf_o, 1'b1);
        check(fpol_o, 8'h77);
        $display("lookup disabled done");
        axi_write(lsl_pkg::REG_FWD_CFG, 32'h1);
        for (int c = 0; c < 8; c++) begin
            lsl_classifier_model_inst.send_frame(8'h5, 3'h0, 3'(c), 3'h0);
            check(spol_o, 8'(8'h12 + c));
            check(stat_o, 8'(8'h82 + c));
        end
        check(mask_o, 8'h0c); check(sf_o, 1'b0);
        check(lag_en_o, 1'b0); check(dec_o, lsl_pkg::DEC_FLOOD);
        check(bpol_o, 8'h33); check(fpol_o, 8'h66);
        check(pol_o, 1'b1);
        $display("flood service done");
        // Group forward, substituted mask, forced lag, dropped early
        axi_write(lsl_pkg::REG_SVC_CTRL, 32'h00a5_0ccd);
        axi_write(lsl_pkg::REG_SVC_MISC, 32'h0300_6633);
        lsl_classifier_model_inst.send_frame(8'h5, 3'h0, 3'h0, 3'h1);
        check(mask_o, 8'h0f); check(lag_o, 4'h9);
        check(dec_o, lsl_pkg::DEC_GROUP); check(grp_o, 8'ha5);
        check(fpol_o, 8'h77); check(pol_o, 1'b0);
        lsl_classifier_model_inst.send_frame(8'h5, 3'h0, 3'h0, 3'h3);
        check(pol_o, 1'b1);
        axi_write(lsl_pkg::REG_SVC_CTRL, 32'h00a5_0dcd);
        lsl_classifier_model_inst.send_frame(8'h5, 3'h0, 3'h0, 3'h0);
        check(dec_o, lsl_pkg::DEC_DEST);
        axi_write(lsl_pkg::REG_SVC_CTRL, 32'h0155_0e00);
        lsl_classifier_model_inst.send_frame(8'h5, 3'h0, 3'h0, 3'h0);
        check(lrn_o, 1'b1); check(lif_o, 11'h555);
        $display("group and learn service done");
        // No service assigned: port and queue defaults
        axi_write(lsl_pkg::REG_FWD_CFG, 32'h7);
        axi_write(lsl_pkg::REG_PORT_CFG, 32'h4021);
        lsl_classifier_model_inst.send_frame(8'h0, 3'h5, 3'h0, 3'h0);
        check(bpol_o, 8'h21); check(spol_o, 8'h45);
        $display("default policers done");
        // Learn cap sources gated by their enables
        axi_write(lsl_pkg::REG_IRQ_MASK, 32'hf);
        lsl_classifier_model_inst.pulse(4'h6);
        rd_check(lsl_pkg::REG_IRQ_STAT, 32'h0);
        axi_write(lsl_pkg::REG_LIMIT_CFG, 32'h3);
        lsl_classifier_model_inst.pulse(4'h1);
        lsl_classifier_model_inst.pulse(4'h2);
        lsl_classifier_model_inst.pulse(4'h4);
        lsl_classifier_model_inst.pulse(4'h8);
        rd_check(lsl_pkg::REG_IRQ_STAT, 32'hf);
        axi_write(lsl_pkg::REG_IRQ_MASK, 32'h5);
        rd_check(lsl_pkg::REG_IRQ_CAUSE, 32'h5);
        check(irq_o, 1'b1);
        axi_write(lsl_pkg::REG_IRQ_STAT, 32'h5);
        rd_check(lsl_pkg::REG_IRQ_STAT, 32'ha);
        rd_check(lsl_pkg::REG_IRQ_CAUSE, 32'h0);
        check(irq_o, 1'b0);
        $display("interrupt sources done");
        give_verdict();
    end
endmodule // lsl_service_lookup_tb
`default_nettype wire
